// [verilog/sbp_port.sv]
// Two six-bit general-purpose ports with write-only direction latches.
// Assumes the core issues file accesses and direction/option loads one per cycle.
`timescale 1ns/1ns
module sbp_port (
   input wire logic clk, // Core instruction clock
   input wire logic rstn, // Async reset, active low
   input wire sbp_pkg::sbp_file_req_t req, // File register access
   output logic [7:0] rdata, // Read data, registered
   input wire logic dir_load, // Direction-load strobe
   input wire logic [2:0] dir_sel, // Direction-load operand
   input wire logic option_load, // Option-load strobe
   input wire logic [7:0] w_reg, // Working register
   input wire sbp_pkg::sbp_cfg_t cfg, // Configuration word
   input wire logic wake_reset, // Reset cause was pin-change wake
   input wire logic [5:0] first_pin_i, // First port pin levels
   output logic [5:0] first_pin_o, // First port drive values
   output logic [5:0] first_pin_oe, // First port drive enables
   input wire logic [5:0] second_pin_i, // Second port pin levels
   output logic [5:0] second_pin_o, // Second port drive values
   output logic [5:0] second_pin_oe, // Second port drive enables
   output logic [5:0] first_pullup_en, // Weak pull-up enables
   output logic wake_event, // Pin change while wake armed
   output logic status_wake_flag, // Status bit 7 value
   output logic timer_clk_in // Timer external clock input
);
   logic [5:0] dir_first_q, dir_second_q;
   logic [5:0] lat_first_q, lat_second_q;
   logic [7:0] option_q;
   logic [5:0] first_pin_s, second_pin_s;
   logic [5:0] snap_q;
   logic wake_flag_q;
   logic [7:0] rdata_q;

   sbp_sync #(.W(6)) u_sync_first (
      .clk(clk),
      .rstn(rstn),
      .d(first_pin_i),
      .q(first_pin_s)
   );

   sbp_sync #(.W(6)) u_sync_second (
      .clk(clk),
      .rstn(rstn),
      .d(second_pin_i),
      .q(second_pin_s)
   );

   wire sel_first = req.addr == sbp_pkg::ADDR_FIRST_PORT;
   wire sel_second = req.addr == sbp_pkg::ADDR_SECOND_PORT;
   wire wr_first = req.wr && sel_first;
   wire wr_second = req.wr && sel_second;
   wire dirld_first = dir_load && (dir_sel == sbp_pkg::DIRLD_FIRST_SEL);
   wire dirld_second = dir_load && (dir_sel == sbp_pkg::DIRLD_SECOND_SEL);
   wire tcs_active = option_q[sbp_pkg::OPT_TCS_BIT];
   wire wake_en = !option_q[sbp_pkg::OPT_WAKE_N_BIT];
   wire pullup_en = !option_q[sbp_pkg::OPT_PULLUP_N_BIT];

   // Reads sample the synchronised pins, alternate functions mask to zero
   wire [5:0] first_read = first_pin_s & ~cfg.alt_first;
   wire [5:0] second_read = second_pin_s & ~cfg.alt_second;
   wire [5:0] sel_read = sel_first ? first_read : (sel_second ? second_read : 6'h00);
   wire [7:0] read_word = {2'h0, sel_read};

   // Enables: zero direction drives; input-only pin excepted, and timer pin while timer source set
   wire [5:0] oe_first_raw = ~dir_first_q;
   wire [5:0] oe_second_raw = ~dir_second_q;
   wire [5:0] input_only_mask = 6'h01 << sbp_pkg::PIN_INPUT_ONLY;
   wire [5:0] timer_mask = tcs_active ? (6'h01 << sbp_pkg::PIN_TIMER_CLK) : 6'h00;

   assign first_pin_oe = oe_first_raw & ~input_only_mask;
   assign second_pin_oe = oe_second_raw & ~timer_mask;
   assign first_pin_o = lat_first_q;
   assign second_pin_o = lat_second_q;
   assign timer_clk_in = second_pin_s[sbp_pkg::PIN_TIMER_CLK];
   assign rdata = rdata_q;
   assign status_wake_flag = wake_flag_q;

   // Group-wide pull-up; reset-pin mode forces it on pin three
   wire [5:0] pu_group = pullup_en ? sbp_pkg::WAKE_GROUP_MASK : 6'h00;
   assign first_pullup_en = pu_group | (cfg.ext_reset_mode ? input_only_mask : 6'h00);

   // Pin three drops out of the wake group when it is the reset input
   wire [5:0] wake_mask = sbp_pkg::WAKE_GROUP_MASK & ~(cfg.ext_reset_mode ? input_only_mask : 6'h00);
   assign wake_event = wake_en && (((first_pin_s ^ snap_q) & wake_mask) != 6'h00);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dir_first_q <= sbp_pkg::DIR_RESET;
         dir_second_q <= sbp_pkg::DIR_RESET;
         option_q <= sbp_pkg::OPTION_RESET;
      end else begin
         if (dirld_first) begin
            dir_first_q <= w_reg[5:0];
         end
         if (dirld_second) begin
            dir_second_q <= w_reg[5:0];
         end
         if (option_load) begin
            option_q <= w_reg;
         end
      end
   end

   // Latches keep their value until rewritten; reset gives a known zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lat_first_q <= 6'h00;
         lat_second_q <= 6'h00;
      end else begin
         if (wr_first) begin
            lat_first_q <= req.wdata[5:0];
         end
         if (wr_second) begin
            lat_second_q <= req.wdata[5:0];
         end
      end
   end

   // Wake reference is the pin state seen on the last read of the first port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         snap_q <= 6'h00;
         rdata_q <= 8'h00;
      end else begin
         if (req.rd && sel_first) begin
            snap_q <= first_pin_s;
         end
         if (req.rd) begin
            rdata_q <= read_word;
         end
      end
   end

   // Reset cause is captured at the first edge after release
   logic cause_taken_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake_flag_q <= 1'b0;
         cause_taken_q <= 1'b0;
      end else if (!cause_taken_q) begin
         wake_flag_q <= wake_reset;
         cause_taken_q <= 1'b1;
      end
   end

   AST_RESET_DIR: assert property (@(posedge clk) $rose(rstn) |-> first_pin_oe == 6'h00 && second_pin_oe == 6'h00)
      else $error("outputs enabled after reset");
   AST_INPUT_ONLY: assert property (@(posedge clk) disable iff (!rstn) !first_pin_oe[3])
      else $error("input-only pin driven");
   AST_TIMER_OVR: assert property (@(posedge clk) disable iff (!rstn) tcs_active |-> !second_pin_oe[5])
      else $error("timer pin driven while timer source set");
   AST_READ_PINS: assert property (@(posedge clk) disable iff (!rstn)
      req.rd && sel_first |=> rdata[5:0] == ($past(first_pin_s) & ~$past(cfg.alt_first)))
      else $error("port read not pin level");
   AST_TOP_ZERO: assert property (@(posedge clk) disable iff (!rstn) rdata[7:6] == 2'h0)
      else $error("unimplemented bits nonzero");
   AST_DIRECTION_LOAD_INSTRUCTION_LOAD: assert property (@(posedge clk) disable iff (!rstn)
      dirld_first |=> first_pin_oe == (~$past(w_reg[5:0]) & 6'h37))
      else $error("direction load not applied");
   AST_WRITE_LATCH: assert property (@(posedge clk) disable iff (!rstn)
      wr_first |=> first_pin_o == $past(req.wdata[5:0]))
      else $error("latch not updated");
   AST_HOLD_LATCH: assert property (@(posedge clk) disable iff (!rstn) !wr_second |=> $stable(second_pin_o))
      else $error("latch changed without write");
   AST_PULLUP_RSTPIN: assert property (@(posedge clk) disable iff (!rstn)
      cfg.ext_reset_mode |-> first_pullup_en[3])
      else $error("reset pin lacks pull-up");
   AST_PULLUP_GROUP: assert property (@(posedge clk) disable iff (!rstn)
      first_pullup_en[0] == first_pullup_en[1] && first_pullup_en[1] == first_pullup_en[4])
      else $error("pull-ups not group-wide");

   // Steps that several checks share are named once here
   sequence s_release;
      $rose(rstn);
   endsequence

   sequence s_read_first;
      req.rd && sel_first;
   endsequence

   sequence s_read_second;
      req.rd && sel_second;
   endsequence

   sequence s_read_none;
      req.rd && !sel_first && !sel_second;
   endsequence

   sequence s_dir_other;
      dir_load && !dirld_first && !dirld_second;
   endsequence

   // Reset leaves the options all ones, so the timer owns its pin at once
   AST_OPT_RESET: assert property (@(posedge clk) s_release |-> tcs_active)
      else $error("timer source not active after reset");

   // Second group must come out of reset with every direction bit set
   AST_DIR2_RESET: assert property (@(posedge clk)
      s_release |-> dir_second_q == sbp_pkg::DIR_RESET)
      else $error("second direction not reset");

   // Cause bit shows the level seen at the first edge after release
   AST_FLAG_CAPTURE: assert property (@(posedge clk)
      s_release |=> status_wake_flag == $past(wake_reset))
      else $error("reset cause not captured");

   // Once captured the cause must not drift with the strobe
   AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      cause_taken_q |=> $stable(status_wake_flag))
      else $error("reset cause changed");

   // Second group load follows the working register, timer pin excepted while timer source set
   AST_DIR2_LOAD: assert property (@(posedge clk) disable iff (!rstn)
      dirld_second |=> second_pin_oe == (~$past(w_reg[5:0]) & ~timer_mask))
      else $error("second direction load not applied");

   // Operands other than the two port codes must leave both groups alone
   AST_DIR_OTHER: assert property (@(posedge clk) disable iff (!rstn)
      s_dir_other |=> $stable(dir_first_q) && $stable(dir_second_q))
      else $error("stray direction load applied");

   // Without a load the direction stays put; it cannot be read back to refresh it
   AST_DIR_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      !dirld_first |=> $stable(dir_first_q))
      else $error("first direction changed without load");

   // Second group latch takes the written byte
   AST_WRITE2_LATCH: assert property (@(posedge clk) disable iff (!rstn)
      wr_second |=> second_pin_o == $past(req.wdata[5:0]))
      else $error("second latch not updated");

   // First group latch holds between writes
   AST_HOLD1_LATCH: assert property (@(posedge clk) disable iff (!rstn)
      !wr_first |=> $stable(first_pin_o))
      else $error("first latch changed without write");

   // Second group read returns pins, never latches
   AST_READ2_PINS: assert property (@(posedge clk) disable iff (!rstn)
      s_read_second |=> rdata[5:0] == ($past(second_pin_s) & ~$past(cfg.alt_second)))
      else $error("second port read not pin level");

   // Unmapped reads must give a clean zero
   AST_READ_NONE: assert property (@(posedge clk) disable iff (!rstn)
      s_read_none |=> rdata == 8'h00)
      else $error("unmapped read nonzero");

   // Alternate-function bits are masked whatever the pin does
   AST_ALT_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      s_read_first |=> (rdata[5:0] & $past(cfg.alt_first)) == 6'h00)
      else $error("alternate pin read nonzero");

   // Read data stands until the next read
   AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      !req.rd |=> $stable(rdata))
      else $error("read data changed without read");

   // Wake stays silent while it is disabled
   AST_WAKE_OFF: assert property (@(posedge clk) disable iff (!rstn)
      !wake_en |-> !wake_event)
      else $error("wake raised while disabled");

   // A change on any group pin must raise wake while armed outside reset-pin mode
   AST_WAKE_SEEN: assert property (@(posedge clk) disable iff (!rstn)
      wake_en && !cfg.ext_reset_mode && (((first_pin_s ^ snap_q) & sbp_pkg::WAKE_GROUP_MASK) != 6'h00)
      |-> wake_event)
      else $error("group pin change missed");

   // In reset-pin mode only pin three differing must not wake
   AST_WAKE_RSTPIN: assert property (@(posedge clk) disable iff (!rstn)
      wake_en && cfg.ext_reset_mode && (((first_pin_s ^ snap_q) & wake_mask) == 6'h00) |-> !wake_event)
      else $error("reset pin caused wake");

   // Pull-ups all off when disabled and pin three is plain input
   AST_PULLUP_OFF: assert property (@(posedge clk) disable iff (!rstn)
      !pullup_en && !cfg.ext_reset_mode |-> first_pullup_en == 6'h00)
      else $error("pull-up on while disabled");

   // Pins outside the group never get a pull-up
   AST_PULLUP_OUTSIDE: assert property (@(posedge clk) disable iff (!rstn)
      !first_pullup_en[2] && !first_pullup_en[5])
      else $error("pull-up outside group");
endmodule

// [verilog/sbp_pkg.sv]
// Constants and carrier types for the six-bit general-purpose port block.
// Assumes the core presents file-register accesses and instruction strobes on clk.
// Operation
// - Port reads return pin levels, not latches
// - Any reset makes every pin high-impedance input
// - Bits 7 and 6 read as zero
// - First-port pin three never drives
// - Alternate-function pins read as zero
// - Pull-ups and wake enabled for group only
// - Reset-pin mode forces pull-up, blocks wake
// - Direction load copies working register
// - Direction one floats pin, zero drives latch
// - Timer clock source overrides pin direction
// - Direction registers write-only, reset to ones
// - Status bit 7 flags pin-change wake reset
// - Latches hold value; inputs sampled at read
// - Read-modify-write sources pin levels
// - Direction load operand six targets first port
package sbp_pkg;
   localparam int PORT_W = 6;
   localparam logic [4:0] ADDR_FIRST_PORT = 5'h06;
   localparam logic [4:0] ADDR_SECOND_PORT = 5'h07;
   localparam logic [2:0] DIRLD_FIRST_SEL = 3'h6;
   localparam logic [2:0] DIRLD_SECOND_SEL = 3'h7;
   localparam logic [5:0] DIR_RESET = 6'h3f;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam int OPT_WAKE_N_BIT = 7;
   localparam int OPT_PULLUP_N_BIT = 6;
   localparam int OPT_TCS_BIT = 5;
   localparam int STATUS_WAKE_BIT = 7;
   localparam int PIN_INPUT_ONLY = 3;
   localparam int PIN_TIMER_CLK = 5;
   localparam logic [5:0] WAKE_GROUP_MASK = 6'h1b;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } sbp_file_req_t;

   typedef struct packed {
      logic [5:0] alt_first;
      logic [5:0] alt_second;
      logic ext_reset_mode;
   } sbp_cfg_t;
endpackage

// [verilog/sbp_sync.sv]
// Two-stage synchroniser for one pin group.
// Assumes the source is asynchronous to clk; only stage two is read outside.
`timescale 1ns/1ns
module sbp_sync #(
   parameter int W = 6
) (
   input wire logic clk, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic [W-1:0] d, // Asynchronous input
   output logic [W-1:0] q // Synchronised output
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// [tb/sbp_pins.sv]
// Outside circuit on one six-pin port group.
// Assumes the bench says which pins are held from outside.
`timescale 1ns/1ns
module sbp_pins (
   input wire logic clk, // Core clock
   input wire logic [5:0] pin_o, // Drive values
   input wire logic [5:0] pin_oe, // Drive enables
   input wire logic [5:0] pu_en, // Pull-up enables
   input wire logic [5:0] ext_en, // Held from outside
   input wire logic [5:0] ext_val, // Level held
   output logic [5:0] pin // Wire level
);
   logic [5:0] float_q = 6'h15;
   // A loose pin wanders so a stale level never passes for a read
   always @(posedge clk) float_q <= ~float_q;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (ext_en[i]) pin[i] = ext_val[i];
         else if (pin_oe[i]) pin[i] = pin_o[i];
         else if (pu_en[i]) pin[i] = 1'b1;
         else pin[i] = float_q[i];
      end
   end
endmodule

// [tb/test_sbp_port.sv]
// Bench for the port block: file accesses, loads and pin stimulus.
// Assumes one pin model per port group resolves the wires.
`timescale 1ns/1ns
module test_sbp_port;
   logic clk = 0, rstn = 0, dir_load = 0, option_load = 0, wake_reset = 0;
   sbp_pkg::sbp_file_req_t req = '0;
   sbp_pkg::sbp_cfg_t cfg = '0;
   logic [2:0] dir_sel = 3'h0;
   logic [7:0] w_reg = 8'h00, rdata;
   logic [5:0] ext_en = 6'h3f, ext_val = 6'h2a, f_i, f_o, f_oe, s_i, s_o, s_oe, pu;
   logic wake_event, status_wake_flag, timer_clk_in;
   int errors = 0, checks = 0;
   sbp_port u_dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .dir_load(dir_load),
      .dir_sel(dir_sel), .option_load(option_load), .w_reg(w_reg), .cfg(cfg), .wake_reset(wake_reset),
      .first_pin_i(f_i), .first_pin_o(f_o), .first_pin_oe(f_oe), .second_pin_i(s_i), .second_pin_o(s_o),
      .second_pin_oe(s_oe), .first_pullup_en(pu), .wake_event(wake_event),
      .status_wake_flag(status_wake_flag), .timer_clk_in(timer_clk_in));
   sbp_pins u_first (.clk(clk), .pin_o(f_o), .pin_oe(f_oe), .pu_en(pu), .ext_en(ext_en),
      .ext_val(ext_val), .pin(f_i));
   sbp_pins u_second (.clk(clk), .pin_o(s_o), .pin_oe(s_oe), .pu_en(6'h00), .ext_en(6'h3f),
      .ext_val(6'h15), .pin(s_i));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
      req = '{wr: wr, rd: ~wr, addr: a, wdata: d};
      cyc(1);
      req = '0;
      cyc(1);
   endtask
   task automatic load(input logic opt, input logic [2:0] sel, input logic [7:0] w);
      option_load = opt;
      dir_load = ~opt;
      dir_sel = sel;
      w_reg = w;
      cyc(1);
      option_load = 0;
      dir_load = 0;
      cyc(1);
   endtask
   task automatic do_reset(input logic wr);
      rstn = 0;
      wake_reset = wr;
      cyc(4);
      rstn = 1;
      cyc(2);
      wake_reset = 0;
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_reset;
      do_reset(0);
      chk({2'h0, f_oe | s_oe}, 8'h00);
      chk({7'h0, status_wake_flag}, 8'h00);
      acc(0, 5'h06, 8'h00);
      chk(rdata, 8'h2a);
      acc(0, 5'h05, 8'h00);
      chk(rdata, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_dir;
      load(0, 3'h6, 8'h00);
      chk({2'h0, f_oe}, 8'h37);
      load(0, 3'h7, 8'h00);
      chk({2'h0, s_oe}, 8'h1f);
      chk({7'h0, timer_clk_in}, 8'h00);
      load(0, 3'h5, 8'hff);
      chk({2'h0, f_oe}, 8'h37);
      load(1, 3'h0, 8'h00);
      chk({2'h0, s_oe}, 8'h3f);
      chk({2'h0, pu}, 8'h1b);
      $display("direction test done");
   endtask
   task automatic t_latch;
      ext_en = 6'h01;
      ext_val = 6'h00;
      acc(1, 5'h06, 8'hff);
      chk({2'h0, f_o}, 8'h3f);
      cyc(2);
      acc(0, 5'h06, 8'h00);
      chk(rdata, 8'h3e);
      cfg.alt_first = 6'h02;
      acc(0, 5'h06, 8'h00);
      chk(rdata, 8'h3c);
      cfg.alt_first = 6'h00;
      acc(1, 5'h07, 8'h15);
      chk({f_o[1:0], s_o}, 8'hd5);
      acc(0, 5'h07, 8'h00);
      chk(rdata, 8'h15);
      $display("latch test done");
   endtask
   task automatic t_wake;
      acc(0, 5'h06, 8'h00);
      ext_val = 6'h01;
      cyc(3);
      chk({7'h0, wake_event}, 8'h01);
      acc(0, 5'h06, 8'h00);
      chk({7'h0, wake_event}, 8'h00);
      cfg.ext_reset_mode = 1;
      ext_en = 6'h09;
      cyc(3);
      chk({7'h0, wake_event}, 8'h00);
      load(1, 3'h0, 8'h40);
      chk({2'h0, pu}, 8'h08);
      cfg.ext_reset_mode = 0;
      cyc(1);
      chk({2'h0, pu}, 8'h00);
      $display("wake test done");
   endtask
   task automatic t_wreset;
      do_reset(1);
      chk({7'h0, status_wake_flag}, 8'h01);
      chk({2'h0, f_oe | s_oe}, 8'h00);
      $display("wake reset test done");
   endtask
   initial begin
      t_reset;
      t_dir;
      t_latch;
      t_wake;
      t_wreset;
      test_done;
   end
   // Tests need under 100 cycles; allow about forty times that
   initial begin
      #200000;
      errors++;
      test_done;
   end
endmodule
